// ---- hdl/exec_core.sv ----
// Execution core for jump, OR, move, idle and option-load instructions
//
// Overview of operation
// - Jump loads nine-bit target into counter low bits
// - Jump copies status page bits into counter top
// - Jump takes two cycles, flags unchanged
// - OR literal into accumulator, update zero
// - OR accumulator with file, update zero
// - Destination bit zero: accumulator; one: file
// - Copy file to destination, update zero
// - Store accumulator into file, flags unchanged
// - Load literal into accumulator, flags unchanged
// - Option load copies accumulator, flags unchanged
`timescale 1ns/1ps

module exec_core
	import exec_pkg::*;
#(
	parameter int FILE_COUNT = 32              // File registers present
)
(
	input  wire logic                             clock,
	input  wire logic                             srst,
	input  wire logic                             clk_en,
	input  wire logic                             instr_valid,
	input  wire logic [exec_pkg::INSTR_WIDTH-1:0] instr_word,
	output logic                                  instr_ready,
	input  wire logic [exec_pkg::FADDR_WIDTH-1:0] peek_addr,
	output logic      [exec_pkg::DATA_WIDTH-1:0]  peek_data,
	output logic      [exec_pkg::PC_WIDTH-1:0]    pc,
	output logic      [exec_pkg::DATA_WIDTH-1:0]  acc,
	output logic      [exec_pkg::DATA_WIDTH-1:0]  status,
	output logic      [exec_pkg::DATA_WIDTH-1:0]  option,
	output logic                                  zero_flag
);
	import exec_pkg::*;

	// Complete state of the core
	typedef struct packed {
		seq_type                              seq;     // Sequencer state
		logic [PC_WIDTH-1:0]                  pc;      // Program counter
		logic [DATA_WIDTH-1:0]                acc;     // Accumulator
		logic [DATA_WIDTH-1:0]                option;  // Option register
		logic [DATA_WIDTH-1:0]                peek;    // File read-back
		logic [FILE_COUNT-1:0][DATA_WIDTH-1:0] files;  // File registers
	} state_type;

	state_type state_q;                        // Registered state
	state_type state_d;                        // Next state

	// Decoded instruction fields
	op_type                  op_dec;           // Operation
	logic [JUMP_K_WIDTH-1:0] jump_k;           // Jump target
	logic [DATA_WIDTH-1:0]   literal;          // Eight-bit literal
	logic [FADDR_WIDTH-1:0]  faddr;            // File address
	logic                    dest;             // Destination selector
	logic                    take;             // Instruction accepted

	// Execution results
	logic [DATA_WIDTH-1:0]   file_val;         // Addressed file value
	logic [DATA_WIDTH-1:0]   result;           // Computed result
	logic                    result_zero;      // Result equals zero
	logic                    zero_upd;         // Zero flag is written
	logic                    acc_wr;           // Accumulator is written
	logic                    file_wr;          // File is written
	logic                    option_wr;        // Option is written

	// Split instruction word into fields
	assign op_dec  = op_type'(instr_word[OP_MSB:OP_LSB]);
	assign jump_k  = instr_word[JUMP_K_MSB:0];
	assign literal = instr_word[LIT_MSB:0];
	assign faddr   = instr_word[FADDR_MSB:0];
	assign dest    = instr_word[DEST_BIT];

	// Ready only in the execute state and while clocked
	assign instr_ready = clk_en && (state_q.seq == SEQ_EXEC);
	assign take        = instr_ready && instr_valid;

	// Out-of-range addresses read as zero
	assign file_val = (32'(faddr) < FILE_COUNT) ?
		state_q.files[faddr] : ZERO_DATA;

	// Result computation and destination decode
	exec_alu exec_alu_inst (
		.op          (op_dec),
		.acc         (state_q.acc),
		.file_val    (file_val),
		.literal     (literal),
		.dest        (dest),
		.result      (result),
		.result_zero (result_zero),
		.zero_upd    (zero_upd),
		.acc_wr      (acc_wr),
		.file_wr     (file_wr),
		.option_wr   (option_wr)
	);

	// Next-state logic
	always_comb
	begin
		state_d = state_q;
		// Read-back port tracks its address each enabled cycle
		state_d.peek = (32'(peek_addr) < FILE_COUNT) ?
			state_q.files[peek_addr] : ZERO_DATA;
		unique case (state_q.seq)
			// Accept and execute one instruction
			SEQ_EXEC:
			begin
				if (take)
				begin
					if (op_dec == OP_JUMP)
					begin
						// Target low bits and page from status
						state_d.pc[JUMP_K_WIDTH-1:0] = jump_k;
						state_d.pc[PAGE_MSB:PAGE_LSB] =
							state_q.files[STATUS_ADDR]
							[STATUS_PAGE_MSB:STATUS_PAGE_LSB];
						// Second cycle discards the next slot
						state_d.seq = SEQ_FLUSH;
					end
					else
					begin
						// Every other operation steps forward
						state_d.pc = state_q.pc + PC_STEP;
					end
					// Accumulator destination
					if (acc_wr)
					begin
						state_d.acc = result;
					end
					// File destination, one entry per address
					for (int i = 0; i < FILE_COUNT; i++)
					begin
						if (file_wr && (32'(faddr) == i))
						begin
							state_d.files[i] = result;
						end
					end
					// Option register load
					if (option_wr)
					begin
						state_d.option = result;
					end
					// Zero flag wins over a write to status
					if (zero_upd)
					begin
						state_d.files[STATUS_ADDR][ZERO_BIT] =
							result_zero;
					end
				end
			end
			// Discarded slot of a jump, only the read-back and the sequencer state change
			SEQ_FLUSH:
			begin
				state_d.seq = SEQ_EXEC;
			end
		endcase
	end

	// State register with clock enable and synchronous reset
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_q.seq    <= SEQ_EXEC;
			state_q.pc     <= PC_RESET;
			state_q.acc    <= DATA_RESET;
			state_q.option <= DATA_RESET;
			state_q.peek   <= DATA_RESET;
			state_q.files  <= '0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
		end
	end

	// Registered outputs
	assign pc        = state_q.pc;
	assign acc       = state_q.acc;
	assign option    = state_q.option;
	assign peek_data = state_q.peek;
	assign status    = state_q.files[STATUS_ADDR];
	assign zero_flag = state_q.files[STATUS_ADDR][ZERO_BIT];

	// Helper copy of the registered status
	logic [DATA_WIDTH-1:0] status_prev;        // Status before the edge
	assign status_prev = state_q.files[STATUS_ADDR];

	// Jump target lands in the low counter bits
	a_jump_target_low: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_JUMP |=>
			pc[JUMP_K_WIDTH-1:0] == $past(jump_k))
		else $error("jump target not loaded into counter");

	// Page bits come from status bits six and five
	a_jump_page_bits: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_JUMP |=>
			pc[PAGE_MSB:PAGE_LSB] ==
			$past(status_prev[STATUS_PAGE_MSB:STATUS_PAGE_LSB]))
		else $error("jump page bits not taken from status");

	// Jump blocks the next slot, then reopens
	a_jump_two_cycle: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_JUMP ##1 clk_en |->
			!instr_ready && status == $past(status) ##1
			state_q.seq == SEQ_EXEC)
		else $error("jump not two cycles or flags changed");

	// OR literal result and zero flag
	a_or_literal: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_OR_LIT |=>
			acc == ($past(acc) | $past(literal)) &&
			zero_flag == (acc == ZERO_DATA))
		else $error("or literal result wrong");

	// OR with file routed to the accumulator
	a_or_file_acc: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_OR_FILE && dest == DEST_ACC |=>
			acc == ($past(acc) | $past(file_val)) &&
			zero_flag == (acc == ZERO_DATA))
		else $error("or with file into accumulator wrong");

	// Destination one writes back the file, not the accumulator
	a_dest_file: assert property (
		@(posedge clock) disable iff (srst)
		take && dest != DEST_ACC && faddr != STATUS_ADDR &&
		(op_dec == OP_OR_FILE || op_dec == OP_COPY) |=>
			acc == $past(acc) &&
			state_q.files[$past(faddr)] == $past(result))
		else $error("file destination not honoured");

	// Copy in place tests the file for zero
	a_copy_zero: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_COPY |=>
			zero_flag == ($past(file_val) == ZERO_DATA))
		else $error("copy did not test for zero");

	// Store keeps flags and writes the file
	a_store_file: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_STORE && faddr != STATUS_ADDR |=>
			state_q.files[$past(faddr)] == $past(acc) &&
			status == $past(status))
		else $error("store to file wrong");

	// Literal load keeps flags
	a_load_literal: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_LOAD_LIT |=>
			acc == $past(literal) && status == $past(status))
		else $error("literal load wrong");

	// Option load copies the accumulator
	a_option_load: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_OPTION |=>
			option == $past(acc) && status == $past(status))
		else $error("option load wrong");

	// Zero flag follows any zero-updating result
	a_zero_flag: assert property (
		@(posedge clock) disable iff (srst)
		take && zero_upd |=> zero_flag == $past(result_zero))
		else $error("zero flag mismatch");

	// Idle changes nothing but the counter
	a_idle_only_pc: assert property (
		@(posedge clock) disable iff (srst)
		take && op_dec == OP_IDLE |=>
			pc == $past(pc) + PC_STEP && acc == $past(acc) &&
			state_q.files == $past(state_q.files) &&
			option == $past(option))
		else $error("idle altered state");

endmodule : exec_core

// ---- hdl/exec_pkg.sv ----
// Shared constants and types for the instruction execution block
package exec_pkg;

	// Instruction word layout
	localparam int INSTR_WIDTH  = 12;        // Bits per instruction word
	localparam int OP_MSB       = 11;        // Operation field, top bit
	localparam int OP_LSB       = 9;         // Operation field, low bit
	localparam int JUMP_K_MSB   = 8;         // Jump target, top bit
	localparam int LIT_MSB      = 7;         // Literal operand, top bit
	localparam int DEST_BIT     = 5;         // Destination selector bit
	localparam int FADDR_MSB    = 4;         // File address, top bit

	// Data path sizes
	localparam int DATA_WIDTH   = 8;         // Accumulator and file width
	localparam int FADDR_WIDTH  = 5;         // File address width
	localparam int PC_WIDTH     = 11;        // Program counter width
	localparam int JUMP_K_WIDTH = 9;         // Jump operand width
	localparam int PAGE_MSB     = 10;        // Page bits in the counter
	localparam int PAGE_LSB     = 9;

	// Status register layout
	localparam logic [FADDR_WIDTH-1:0] STATUS_ADDR = 5'h03;
	localparam int STATUS_PAGE_MSB = 6;      // Page select, top bit
	localparam int STATUS_PAGE_LSB = 5;      // Page select, low bit
	localparam int ZERO_BIT        = 2;      // Zero flag position

	// Reset values and other constants
	localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
	localparam logic [PC_WIDTH-1:0]   PC_RESET   = 11'h000;
	localparam logic [PC_WIDTH-1:0]   PC_STEP    = 11'h001;
	localparam logic [DATA_WIDTH-1:0] ZERO_DATA  = 8'h00;
	localparam logic                  DEST_ACC   = 1'b0;

	// Operation codes carried in the operation field
	typedef enum logic [2:0] {
		OP_IDLE     = 3'h0,  // idle_instruction
		OP_JUMP     = 3'h1,  // jump_absolute
		OP_OR_LIT   = 3'h2,  // or_literal_into_acc
		OP_OR_FILE  = 3'h3,  // or_acc_with_file
		OP_STORE    = 3'h4,  // store_acc_to_file
		OP_COPY     = 3'h5,  // copy_file_reg
		OP_LOAD_LIT = 3'h6,  // load_literal_acc
		OP_OPTION   = 3'h7   // load option register
	} op_type;

	// Sequencer states, Gray coded
	typedef enum logic {
		SEQ_EXEC  = 1'b0,    // Accepting instructions
		SEQ_FLUSH = 1'b1     // Second cycle of a jump
	} seq_type;

endpackage : exec_pkg

// ---- hdl/exec_alu.sv ----
// Result and write-enable logic for one executed instruction
`timescale 1ns/1ps

module exec_alu
(
	input  wire exec_pkg::op_type                op,
	input  wire logic [exec_pkg::DATA_WIDTH-1:0] acc,
	input  wire logic [exec_pkg::DATA_WIDTH-1:0] file_val,
	input  wire logic [exec_pkg::DATA_WIDTH-1:0] literal,
	input  wire logic                            dest,
	output logic      [exec_pkg::DATA_WIDTH-1:0] result,
	output logic                                 result_zero,
	output logic                                 zero_upd,
	output logic                                 acc_wr,
	output logic                                 file_wr,
	output logic                                 option_wr
);
	import exec_pkg::*;

	// Decode operation into result and destination enables
	always_comb
	begin
		result    = acc;
		zero_upd  = 1'b0;
		acc_wr    = 1'b0;
		file_wr   = 1'b0;
		option_wr = 1'b0;
		unique case (op)
			// Accumulator OR literal, back to accumulator
			OP_OR_LIT:
			begin
				result   = acc | literal;
				zero_upd = 1'b1;
				acc_wr   = 1'b1;
			end
			// Accumulator OR file, routed by destination
			OP_OR_FILE:
			begin
				result   = acc | file_val;
				zero_upd = 1'b1;
				acc_wr   = (dest == DEST_ACC);
				file_wr  = (dest != DEST_ACC);
			end
			// File contents to destination
			OP_COPY:
			begin
				result   = file_val;
				zero_upd = 1'b1;
				acc_wr   = (dest == DEST_ACC);
				file_wr  = (dest != DEST_ACC);
			end
			// Accumulator into file, flags untouched
			OP_STORE:
			begin
				result  = acc;
				file_wr = 1'b1;
			end
			// Literal into accumulator, flags untouched
			OP_LOAD_LIT:
			begin
				result = literal;
				acc_wr = 1'b1;
			end
			// Accumulator into option register
			OP_OPTION:
			begin
				result    = acc;
				option_wr = 1'b1;
			end
			// Jump and idle write nothing here
			OP_JUMP, OP_IDLE:
			begin
				result = acc;
			end
		endcase
	end

	// Zero test on the full result
	assign result_zero = (result == ZERO_DATA);

endmodule : exec_alu

// ---- dv/tb.sv ----
// Self-checking testbench for the instruction execution core
`timescale 1ns/1ps

`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
		end \
	end

module tb;
	import exec_pkg::*;

	logic                   clock;       // Core clock
	logic                   srst;        // Synchronous reset
	logic                   clk_en;      // Run enable
	logic                   instr_valid; // Instruction offered
	logic [INSTR_WIDTH-1:0] instr_word;  // Offered instruction
	logic                   instr_ready; // Core takes the word
	logic [FADDR_WIDTH-1:0] peek_addr;   // File read-back address
	logic [DATA_WIDTH-1:0]  peek_data;   // File read-back data
	logic [PC_WIDTH-1:0]    pc;          // Program counter
	logic [DATA_WIDTH-1:0]  acc;         // Accumulator
	logic [DATA_WIDTH-1:0]  status;      // Status register
	logic [DATA_WIDTH-1:0]  option;      // Option register
	logic                   zero_flag;   // Zero flag
	int                     failures;    // Mismatch count
	int                     tests_run;   // Comparison count
	logic [PC_WIDTH-1:0]    m_pc;        // Expected counter
	logic [DATA_WIDTH-1:0]  m_st;        // Expected status
	logic [DATA_WIDTH-1:0]  rd;          // Read-back value

	// Device under test
	exec_core #(
		.FILE_COUNT(32)
	) exec_core_inst (
		.clock      (clock),
		.srst       (srst),
		.clk_en     (clk_en),
		.instr_valid(instr_valid),
		.instr_word (instr_word),
		.instr_ready(instr_ready),
		.peek_addr  (peek_addr),
		.peek_data  (peek_data),
		.pc         (pc),
		.acc        (acc),
		.status     (status),
		.option     (option),
		.zero_flag  (zero_flag)
	);

	// Free-running 250 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Verdict and end of run
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// One edge, then the drive delay
	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick

	// File-register operation word
	function automatic logic [INSTR_WIDTH-1:0] wf(input op_type op,
		input logic d, input logic [FADDR_WIDTH-1:0] f);
		return {op, 3'h0, d, f};
	endfunction : wf

	// Literal operation word
	function automatic logic [INSTR_WIDTH-1:0] wl(input op_type op,
		input logic [DATA_WIDTH-1:0] k);
		return {op, 1'b0, k};
	endfunction : wl

	// Offer one word, hold it until taken, track the counter
	task automatic issue(input logic [INSTR_WIDTH-1:0] w);
		int n;
		n = 0;
		// Let one edge pass with valid low between two offers
		tick();
		instr_valid = 1'b1;
		instr_word  = w;
		while (instr_ready !== 1'b1 && n < 8)
		begin
			tick();
			n++;
		end
		if (n == 8)
		begin
			failures++;
			wrap_up();
		end
		tick();
		instr_valid = 1'b0;
		if (w[OP_MSB:OP_LSB] == OP_JUMP)
			m_pc = {m_st[6:5], w[8:0]};
		else
			m_pc = m_pc + PC_STEP;
	endtask : issue

	// Read one file register back
	task automatic peek(input logic [FADDR_WIDTH-1:0] a,
		output logic [DATA_WIDTH-1:0] v);
		peek_addr = a;
		tick();
		v = peek_data;
	endtask : peek

	// Reset held for ten cycles, then state checked
	task automatic t_reset;
		srst = 1'b1;
		repeat (10) tick();
		srst = 1'b0;
		m_pc = PC_RESET;
		m_st = 8'h00;
		`CHK(pc, PC_RESET)
		`CHK(acc, DATA_RESET)
		`CHK(option, DATA_RESET)
		`CHK(status, DATA_RESET)
		`CHK(instr_ready, 1'b1)
		peek(5'h1F, rd);
		`CHK(rd, DATA_RESET)
		$display("Test done: reset");
	endtask : t_reset

	// Literal loads and literal OR with zero flag
	task automatic t_literal;
		issue(wl(OP_LOAD_LIT, 8'h00));
		`CHK(acc, 8'h00)
		`CHK(zero_flag, 1'b0)
		issue(wl(OP_OR_LIT, 8'h00));
		`CHK(zero_flag, 1'b1)
		issue(wl(OP_LOAD_LIT, 8'hFF));
		`CHK(zero_flag, 1'b1)
		`CHK(pc, m_pc)
		issue(wl(OP_LOAD_LIT, 8'h00));
		issue(wl(OP_OR_LIT, 8'h5A));
		`CHK(acc, 8'h5A)
		`CHK(zero_flag, 1'b0)
		$display("Test done: literal");
	endtask : t_literal

	// Accumulator stores to both address ends
	task automatic t_store;
		issue(wf(OP_STORE, 1'b1, 5'h1F));
		issue(wf(OP_STORE, 1'b1, 5'h00));
		`CHK(status, 8'h00)
		peek(5'h1F, rd);
		`CHK(rd, 8'h5A)
		peek(5'h00, rd);
		`CHK(rd, 8'h5A)
		$display("Test done: store");
	endtask : t_store

	// OR with file to either destination
	task automatic t_or_file;
		issue(wl(OP_LOAD_LIT, 8'h81));
		issue(wf(OP_OR_FILE, 1'b0, 5'h00));
		`CHK(acc, 8'hDB)
		peek(5'h00, rd);
		`CHK(rd, 8'h5A)
		issue(wl(OP_LOAD_LIT, 8'h24));
		issue(wf(OP_OR_FILE, 1'b1, 5'h1F));
		`CHK(acc, 8'h24)
		peek(5'h1F, rd);
		`CHK(rd, 8'h7E)
		issue(wl(OP_LOAD_LIT, 8'h00));
		issue(wf(OP_OR_FILE, 1'b0, 5'h0A));
		`CHK(zero_flag, 1'b1)
		$display("Test done: or file");
	endtask : t_or_file

	// Copy as zero test and copy into accumulator
	task automatic t_copy;
		issue(wl(OP_LOAD_LIT, 8'h01));
		issue(wl(OP_OR_LIT, 8'h00));
		issue(wf(OP_COPY, 1'b1, 5'h0A));
		`CHK(zero_flag, 1'b1)
		`CHK(acc, 8'h01)
		issue(wf(OP_COPY, 1'b0, 5'h1F));
		`CHK(acc, 8'h7E)
		`CHK(zero_flag, 1'b0)
		$display("Test done: copy");
	endtask : t_copy

	// Option load keeps a set zero flag
	task automatic t_option;
		issue(wl(OP_LOAD_LIT, 8'h00));
		issue(wl(OP_OR_LIT, 8'h00));
		issue(wl(OP_LOAD_LIT, 8'hA5));
		issue(wf(OP_OPTION, 1'b0, 5'h00));
		`CHK(option, 8'hA5)
		`CHK(zero_flag, 1'b1)
		m_st = 8'h04;
		$display("Test done: option");
	endtask : t_option

	// Idle leaves everything but the counter
	task automatic t_idle;
		issue(wf(OP_IDLE, 1'b0, 5'h00));
		`CHK(pc, m_pc)
		`CHK(acc, 8'hA5)
		`CHK(option, 8'hA5)
		`CHK(status, m_st)
		peek(5'h1F, rd);
		`CHK(rd, 8'h7E)
		$display("Test done: idle");
	endtask : t_idle

	// Jumps to pages three and one, each followed by another instruction
	task automatic t_jump;
		issue(wl(OP_LOAD_LIT, 8'h60));
		issue(wf(OP_STORE, 1'b1, STATUS_ADDR));
		m_st = 8'h60;
		issue({OP_JUMP, 9'h1FF});
		`CHK(pc, 11'h7FF)
		`CHK(instr_ready, 1'b0)
		`CHK(status, 8'h60)
		tick();
		`CHK(instr_ready, 1'b1)
		`CHK(pc, 11'h7FF)
		issue(wf(OP_IDLE, 1'b0, 5'h00));
		`CHK(pc, 11'h000)
		issue(wl(OP_LOAD_LIT, 8'h20));
		issue(wf(OP_STORE, 1'b1, STATUS_ADDR));
		m_st = 8'h20;
		issue({OP_JUMP, 9'h000});
		`CHK(pc, 11'h200)
		issue(wl(OP_LOAD_LIT, 8'h3C));
		`CHK(pc, 11'h201)
		`CHK(acc, 8'h3C)
		$display("Test done: jump");
	endtask : t_jump

	// Enable low freezes the core with a word offered
	task automatic t_freeze;
		// Valid was just lowered, so let an edge pass first
		tick();
		clk_en      = 1'b0;
		instr_valid = 1'b1;
		instr_word  = wl(OP_LOAD_LIT, 8'h99);
		repeat (3) tick();
		`CHK(instr_ready, 1'b0)
		`CHK(acc, 8'h3C)
		`CHK(pc, m_pc)
		clk_en = 1'b1;
		tick();
		instr_valid = 1'b0;
		`CHK(acc, 8'h99)
		$display("Test done: freeze");
	endtask : t_freeze

	// Main sequence
	initial
	begin
		failures    = 0;
		tests_run   = 0;
		srst        = 1'b1;
		clk_en      = 1'b1;
		instr_valid = 1'b0;
		instr_word  = '0;
		peek_addr   = '0;
		tick();
		t_reset();
		t_literal();
		t_store();
		t_or_file();
		t_copy();
		t_option();
		t_idle();
		t_jump();
		t_freeze();
		t_reset();
		wrap_up();
	end

endmodule : tb
